// File: hdl/sbsl_pkg.sv
// package for the servo brake and status logic
// assumes a 250 MHz drive clock and 32-bit axi4-lite register access
package sbsl_pkg;
   // ****************************************
   // register byte offsets
   // ****************************************
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_ROT_SPD = 8'h04;
   localparam logic [7:0] OFS_OVF_THR = 8'h08;
   localparam logic [7:0] OFS_POS_THR = 8'h0C;
   localparam logic [7:0] OFS_COIN_DIF = 8'h10;
   localparam logic [7:0] OFS_SON_WAIT = 8'h14;
   localparam logic [7:0] OFS_BRK_SPD = 8'h18;
   localparam logic [7:0] OFS_BRK_TIME = 8'h1C;
   localparam logic [7:0] OFS_IN_ASSIGN = 8'h20;
   localparam logic [7:0] OFS_OUT_ASSIGN = 8'h24;
   localparam logic [7:0] OFS_STATUS = 8'h28;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h2C;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h30;
   localparam logic [7:0] OFS_FUNC_VIEW = 8'h34;
   // ****************************************
   // fields
   // ****************************************
   localparam int CTRL_SERVO_ON = 0;
   localparam int CTRL_POS_MODE = 1;
   localparam int ST_ROT = 0;
   localparam int ST_COIN = 1;
   localparam int ST_POSC = 2;
   localparam int ST_OVF = 3;
   localparam int ST_BRAKE = 4;
   localparam int ST_EXCITE = 5;
   localparam int NUM_IRQ = 4;
   localparam int IRQ_OVF = 0;
   localparam int IRQ_ROT = 1;
   localparam int IRQ_POSC = 2;
   localparam int IRQ_BRAKE = 3;
   localparam int OVF_SHIFT = 8;         // threshold unit is 256 pulses
   localparam int NUM_TERM = 8;
   localparam int NUM_OUT = 3;
   localparam int NUM_FUNC = 16;
   localparam logic [3:0] FUNC_BRAKE = 4'h4;  // output code for brake output
   // ****************************************
   // reset values and timing
   // ****************************************
   localparam logic [31:0] RST_ZERO = 32'h0000_0000;
   localparam logic [31:0] RST_OUT_ASSIGN = 32'h0000_0210;
   localparam logic [31:0] RST_IN_ASSIGN = 32'h7654_3210;
   localparam int CLK_MHZ = 250;
   localparam int TICK_US = 1000;        // wait times count in ms
   localparam int TICK_CYC = CLK_MHZ * TICK_US;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   typedef enum logic [1:0] {SBSL_OFF, SBSL_ON_WAIT, SBSL_RUN, SBSL_OFF_WAIT} sbsl_state_t;
endpackage : sbsl_pkg

// File: hdl/sbsl_tick.sv
// free-running time base for the brake sequencer
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ns
`default_nettype none
module sbsl_tick
   import sbsl_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   output logic tick
);
   logic [17:0] cnt_reg;
   logic [17:0] cnt_next;
   logic tick_reg;
   logic tick_next;
   // ****************************************
   // divider
   // ****************************************
   // one-cycle pulse every millisecond
   always_comb begin
      tick_next = 1'b0;
      cnt_next = cnt_reg + 18'h0_0001;
      if (cnt_reg == 18'(TICK_CYC - 1)) begin
         cnt_next = 18'h0_0000;
         tick_next = 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         cnt_reg <= 18'h0_0000;
         tick_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         tick_reg <= tick_next;
      end
   end
   assign tick = tick_reg;
endmodule : sbsl_tick
`default_nettype wire

// File: hdl/sbsl_top.sv
// servo status outputs, holding-brake sequence and terminal allocation
// assumes axi4-lite master on CLK; motor inputs and terminals are asynchronous
`timescale 1ns/1ns
`default_nettype none
module sbsl_top
   import sbsl_pkg::*;
(
   input wire logic CLK,
   input wire logic SRST,
   input wire logic [31:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [31:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic [15:0] MOTOR_SPEED,
   input wire logic [15:0] SPEED_REF,
   input wire logic [31:0] POS_ERROR,
   input wire logic [7:0] INPUT_TERMINALS,
   output logic [15:0] INPUT_FUNCTIONS,
   output logic [2:0] OUTPUT_TERMINALS,
   output logic MOTOR_EXCITE,
   output logic IRQ
);
   // ****************************************
   // input synchronisers
   // ****************************************
   logic [15:0] spd_s1_reg, spd_s2_reg, ref_s1_reg, ref_s2_reg;
   logic [31:0] perr_s1_reg, perr_s2_reg;
   logic [7:0] term_s1_reg, term_s2_reg;
   // multi-bit words are assumed to be held stable by the sensor between updates
   always_ff @(posedge CLK) begin
      if (SRST) begin
         spd_s1_reg <= 16'h0000;
         spd_s2_reg <= 16'h0000;
         ref_s1_reg <= 16'h0000;
         ref_s2_reg <= 16'h0000;
         perr_s1_reg <= 32'h0000_0000;
         perr_s2_reg <= 32'h0000_0000;
         term_s1_reg <= 8'h00;
         term_s2_reg <= 8'h00;
      end else begin
         spd_s1_reg <= MOTOR_SPEED;
         spd_s2_reg <= spd_s1_reg;
         ref_s1_reg <= SPEED_REF;
         ref_s2_reg <= ref_s1_reg;
         perr_s1_reg <= POS_ERROR;
         perr_s2_reg <= perr_s1_reg;
         term_s1_reg <= INPUT_TERMINALS;
         term_s2_reg <= term_s1_reg;
      end
   end
   // ****************************************
   // register file and axi4-lite slave
   // ****************************************
   logic [31:0] ctrl_reg, rot_spd_reg, ovf_thr_reg, pos_thr_reg, coin_reg, son_reg;
   logic [31:0] bspd_reg, btime_reg, in_asg_reg, out_asg_reg;
   logic [31:0] ctrl_next, rot_spd_next, ovf_thr_next, pos_thr_next, coin_next, son_next;
   logic [31:0] bspd_next, btime_next, in_asg_next, out_asg_next;
   logic [NUM_IRQ-1:0] ists_reg, ists_next, imask_reg, imask_next, ev;
   logic awready_reg, awready_next, wready_reg, wready_next, bvalid_reg, bvalid_next;
   logic arready_reg, arready_next, rvalid_reg, rvalid_next;
   logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
   logic [31:0] rdata_reg, rdata_next, rd_val, wmask;
   logic [7:0] awaddr_reg, awaddr_next;
   logic [31:0] wdata_reg, wdata_next;
   logic [3:0] wstrb_reg, wstrb_next;
   logic aw_have_reg, aw_have_next, w_have_reg, w_have_next, rd_hit, wr_hit, do_wr;
   logic [5:0] status_vec;
   logic [31:0] func_view;
   // byte-lane mask of the captured write
   always_comb begin
      for (int b = 0; b < 4; b++) begin
         wmask[b*8 +: 8] = {8{wstrb_reg[b]}};
      end
   end
   // read mux; unmapped addresses answer slverr
   always_comb begin
      rd_hit = 1'b1;
      case (S_AXI_ARADDR[7:0])
         OFS_CTRL: rd_val = ctrl_reg;
         OFS_ROT_SPD: rd_val = rot_spd_reg;
         OFS_OVF_THR: rd_val = ovf_thr_reg;
         OFS_POS_THR: rd_val = pos_thr_reg;
         OFS_COIN_DIF: rd_val = coin_reg;
         OFS_SON_WAIT: rd_val = son_reg;
         OFS_BRK_SPD: rd_val = bspd_reg;
         OFS_BRK_TIME: rd_val = btime_reg;
         OFS_IN_ASSIGN: rd_val = in_asg_reg;
         OFS_OUT_ASSIGN: rd_val = out_asg_reg;
         OFS_STATUS: rd_val = {26'h000_0000, status_vec};
         OFS_IRQ_STAT: rd_val = {28'h000_0000, ists_reg};
         OFS_IRQ_MASK: rd_val = {28'h000_0000, imask_reg};
         OFS_FUNC_VIEW: rd_val = func_view;
         default: begin
            rd_val = 32'h0000_0000;
            rd_hit = 1'b0;
         end
      endcase
   end
   // write path: address and data captured in either order, then one response
   always_comb begin
      awready_next = 1'b0;
      wready_next = 1'b0;
      arready_next = 1'b0;
      aw_have_next = aw_have_reg;
      w_have_next = w_have_reg;
      awaddr_next = awaddr_reg;
      wdata_next = wdata_reg;
      wstrb_next = wstrb_reg;
      bvalid_next = bvalid_reg && !S_AXI_BREADY;
      bresp_next = bresp_reg;
      rvalid_next = rvalid_reg && !S_AXI_RREADY;
      rresp_next = rresp_reg;
      rdata_next = rdata_reg;
      do_wr = 1'b0;
      wr_hit = 1'b1;
      if (S_AXI_AWVALID && !aw_have_reg && !awready_reg && !bvalid_reg) begin
         awready_next = 1'b1;
      end
      if (S_AXI_AWVALID && awready_reg) begin
         aw_have_next = 1'b1;
         awaddr_next = S_AXI_AWADDR[7:0];
      end
      if (S_AXI_WVALID && !w_have_reg && !wready_reg && !bvalid_reg) begin
         wready_next = 1'b1;
      end
      if (S_AXI_WVALID && wready_reg) begin
         w_have_next = 1'b1;
         wdata_next = S_AXI_WDATA;
         wstrb_next = S_AXI_WSTRB;
      end
      if (aw_have_reg && w_have_reg && !bvalid_reg) begin
         do_wr = 1'b1;
         aw_have_next = 1'b0;
         w_have_next = 1'b0;
         bvalid_next = 1'b1;
         wr_hit = (awaddr_reg <= OFS_FUNC_VIEW) && (awaddr_reg[1:0] == 2'b00);
         bresp_next = wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (S_AXI_ARVALID && !arready_reg && !rvalid_reg) begin
         arready_next = 1'b1;
      end
      if (S_AXI_ARVALID && arready_reg) begin
         rvalid_next = 1'b1;
         rdata_next = rd_val;
         rresp_next = rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
   end
   // register writes; hardware events win over the write-one clear
   always_comb begin
      ctrl_next = ctrl_reg;
      rot_spd_next = rot_spd_reg;
      ovf_thr_next = ovf_thr_reg;
      pos_thr_next = pos_thr_reg;
      coin_next = coin_reg;
      son_next = son_reg;
      bspd_next = bspd_reg;
      btime_next = btime_reg;
      in_asg_next = in_asg_reg;
      out_asg_next = out_asg_reg;
      imask_next = imask_reg;
      ists_next = ists_reg;
      if (do_wr) begin
         case (awaddr_reg)
            OFS_CTRL: ctrl_next = (ctrl_reg & ~wmask) | (wdata_reg & wmask);
            OFS_ROT_SPD: rot_spd_next = (rot_spd_reg & ~wmask) | (wdata_reg & wmask);
            OFS_OVF_THR: ovf_thr_next = (ovf_thr_reg & ~wmask) | (wdata_reg & wmask);
            OFS_POS_THR: pos_thr_next = (pos_thr_reg & ~wmask) | (wdata_reg & wmask);
            OFS_COIN_DIF: coin_next = (coin_reg & ~wmask) | (wdata_reg & wmask);
            OFS_SON_WAIT: son_next = (son_reg & ~wmask) | (wdata_reg & wmask);
            OFS_BRK_SPD: bspd_next = (bspd_reg & ~wmask) | (wdata_reg & wmask);
            OFS_BRK_TIME: btime_next = (btime_reg & ~wmask) | (wdata_reg & wmask);
            OFS_IN_ASSIGN: in_asg_next = (in_asg_reg & ~wmask) | (wdata_reg & wmask);
            OFS_OUT_ASSIGN: out_asg_next = (out_asg_reg & ~wmask) | (wdata_reg & wmask);
            OFS_IRQ_STAT: ists_next = ists_reg & ~(wdata_reg[NUM_IRQ-1:0] & wmask[NUM_IRQ-1:0]);
            OFS_IRQ_MASK: imask_next = (imask_reg & ~wmask[NUM_IRQ-1:0])
                                     | (wdata_reg[NUM_IRQ-1:0] & wmask[NUM_IRQ-1:0]);
            default: ;
         endcase
      end
      ists_next = ists_next | ev;
   end
   always_ff @(posedge CLK) begin
      if (SRST) begin
         ctrl_reg <= RST_ZERO;
         rot_spd_reg <= RST_ZERO;
         ovf_thr_reg <= RST_ZERO;
         pos_thr_reg <= RST_ZERO;
         coin_reg <= RST_ZERO;
         son_reg <= RST_ZERO;
         bspd_reg <= RST_ZERO;
         btime_reg <= RST_ZERO;
         in_asg_reg <= RST_IN_ASSIGN;
         out_asg_reg <= RST_OUT_ASSIGN;
         ists_reg <= 4'h0;
         imask_reg <= 4'h0;
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         arready_reg <= 1'b0;
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         awaddr_reg <= 8'h00;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
         rvalid_reg <= 1'b0;
         rresp_reg <= RESP_OKAY;
         rdata_reg <= 32'h0000_0000;
      end else begin
         ctrl_reg <= ctrl_next;
         rot_spd_reg <= rot_spd_next;
         ovf_thr_reg <= ovf_thr_next;
         pos_thr_reg <= pos_thr_next;
         coin_reg <= coin_next;
         son_reg <= son_next;
         bspd_reg <= bspd_next;
         btime_reg <= btime_next;
         in_asg_reg <= in_asg_next;
         out_asg_reg <= out_asg_next;
         ists_reg <= ists_next;
         imask_reg <= imask_next;
         awready_reg <= awready_next;
         wready_reg <= wready_next;
         arready_reg <= arready_next;
         aw_have_reg <= aw_have_next;
         w_have_reg <= w_have_next;
         awaddr_reg <= awaddr_next;
         wdata_reg <= wdata_next;
         wstrb_reg <= wstrb_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         rvalid_reg <= rvalid_next;
         rresp_reg <= rresp_next;
         rdata_reg <= rdata_next;
      end
   end
   // ****************************************
   // status comparators
   // ****************************************
   logic rot_reg, rot_next, coin_o_reg, coin_o_next, posc_reg, posc_next, ovf_reg, ovf_next;
   logic [15:0] spd_abs, spd_diff;
   logic [31:0] perr_abs;
   logic pos_mode;
   // speeds are signed rpm, error counter signed pulses
   always_comb begin
      pos_mode = ctrl_reg[CTRL_POS_MODE];
      spd_abs = spd_s2_reg[15] ? 16'(-spd_s2_reg) : spd_s2_reg;
      spd_diff = 16'(ref_s2_reg - spd_s2_reg);
      if (spd_diff[15]) begin
         spd_diff = 16'(-spd_diff);
      end
      perr_abs = perr_s2_reg[31] ? 32'(-perr_s2_reg) : perr_s2_reg;
      rot_next = spd_abs > rot_spd_reg[15:0];
      coin_o_next = spd_diff < coin_reg[15:0];
      posc_next = pos_mode && (perr_abs < pos_thr_reg);
      ovf_next = pos_mode && ({8'h00, perr_abs} > {ovf_thr_reg, 8'h00});
   end
   // ****************************************
   // brake sequencer
   // ****************************************
   sbsl_state_t st_reg, st_next;
   logic [31:0] tcnt_reg, tcnt_next;
   logic brk_reg, brk_next, exc_reg, exc_next, son_prev_reg, tick, brake_asg;
   logic signed [31:0] son_wait;
   logic [31:0] son_mag;
   sbsl_tick u_tick (
      .clk(CLK),
      .srst(SRST),
      .tick(tick)
   );
   // brk_reg high means brake released (brake output active)
   always_comb begin
      brake_asg = 1'b0;
      for (int k = 0; k < NUM_OUT; k++) begin
         if (out_asg_reg[k*4 +: 4] == FUNC_BRAKE) begin
            brake_asg = 1'b1;
         end
      end
      son_wait = signed'(son_reg);
      son_mag = son_wait[31] ? 32'(-son_wait) : son_reg;
      st_next = st_reg;
      tcnt_next = tick ? tcnt_reg + 32'h0000_0001 : tcnt_reg;
      brk_next = brk_reg;
      exc_next = exc_reg;
      case (st_reg)
         SBSL_OFF: begin
            exc_next = 1'b0;
            brk_next = 1'b0;
            if (ctrl_reg[CTRL_SERVO_ON] && !son_prev_reg) begin
               tcnt_next = 32'h0000_0000;
               if (!brake_asg || son_mag == 32'h0000_0000) begin
                  exc_next = 1'b1;
                  brk_next = 1'b1;
                  st_next = SBSL_RUN;
               end else begin
                  brk_next = !son_wait[31];
                  exc_next = son_wait[31];
                  st_next = SBSL_ON_WAIT;
               end
            end
         end
         SBSL_ON_WAIT: begin
            if (!ctrl_reg[CTRL_SERVO_ON]) begin
               exc_next = 1'b0;
               brk_next = 1'b0;
               st_next = SBSL_OFF;
            end else if (tcnt_reg >= son_mag) begin
               exc_next = 1'b1;
               brk_next = 1'b1;
               st_next = SBSL_RUN;
            end
         end
         SBSL_RUN: begin
            if (!ctrl_reg[CTRL_SERVO_ON]) begin
               exc_next = 1'b0;
               tcnt_next = 32'h0000_0000;
               if (!brake_asg || (bspd_reg == 32'h0000_0000 && btime_reg == 32'h0000_0000)) begin
                  brk_next = 1'b0;
                  st_next = SBSL_OFF;
               end else begin
                  st_next = SBSL_OFF_WAIT;
               end
            end
         end
         SBSL_OFF_WAIT: begin
            // either condition ends the wait
            if (({16'h0000, spd_abs} < bspd_reg) || (tcnt_reg > btime_reg)) begin
               brk_next = 1'b0;
               st_next = SBSL_OFF;
            end
         end
         default: st_next = SBSL_OFF;
      endcase
   end
   always_ff @(posedge CLK) begin
      if (SRST) begin
         st_reg <= SBSL_OFF;
         tcnt_reg <= 32'h0000_0000;
         brk_reg <= 1'b0;
         exc_reg <= 1'b0;
         son_prev_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         tcnt_reg <= tcnt_next;
         brk_reg <= brk_next;
         exc_reg <= exc_next;
         son_prev_reg <= (st_next == SBSL_OFF) ? 1'b0 : 1'b1;
      end
   end
   // ****************************************
   // terminal allocation and outputs
   // ****************************************
   logic [NUM_FUNC-1:0] infunc_next, infunc_reg;
   logic [2:0] outterm_next, outterm_reg;
   logic irq_reg;
   logic [3:0] ostat [0:NUM_FUNC-1];
   // last terminal written first so the first terminal wins a duplicate
   always_comb begin
      infunc_next = '0;
      for (int t = NUM_TERM - 1; t >= 0; t--) begin
         infunc_next[in_asg_reg[t*4 +: 4]] = term_s2_reg[t];
      end
      for (int f = 0; f < NUM_FUNC; f++) begin
         ostat[f] = 4'h0;
      end
      ostat[0] = {3'h0, pos_mode ? posc_reg : coin_o_reg};
      ostat[1] = {3'h0, rot_reg};
      ostat[4] = {3'h0, brk_reg};
      for (int o = 0; o < NUM_OUT; o++) begin
         outterm_next[o] = ostat[out_asg_reg[o*4 +: 4]][0];
      end
      ev = {brk_reg & ~brk_next, posc_next & ~posc_reg, rot_next & ~rot_reg, ovf_next & ~ovf_reg};
   end
   assign status_vec = {exc_reg, brk_reg, ovf_reg, posc_reg, coin_o_reg, rot_reg};
   assign func_view = {16'h0000, infunc_reg};
   always_ff @(posedge CLK) begin
      if (SRST) begin
         rot_reg <= 1'b0;
         coin_o_reg <= 1'b0;
         posc_reg <= 1'b0;
         ovf_reg <= 1'b0;
         infunc_reg <= 16'h0000;
         outterm_reg <= 3'h0;
         irq_reg <= 1'b0;
      end else begin
         rot_reg <= rot_next;
         coin_o_reg <= coin_o_next;
         posc_reg <= posc_next;
         ovf_reg <= ovf_next;
         infunc_reg <= infunc_next;
         outterm_reg <= outterm_next;
         irq_reg <= |(ists_next & imask_next);
      end
   end
   assign S_AXI_AWREADY = awready_reg;
   assign S_AXI_WREADY = wready_reg;
   assign S_AXI_BRESP = bresp_reg;
   assign S_AXI_BVALID = bvalid_reg;
   assign S_AXI_ARREADY = arready_reg;
   assign S_AXI_RDATA = rdata_reg;
   assign S_AXI_RRESP = rresp_reg;
   assign S_AXI_RVALID = rvalid_reg;
   assign INPUT_FUNCTIONS = infunc_reg;
   assign OUTPUT_TERMINALS = outterm_reg;
   assign MOTOR_EXCITE = exc_reg;
   assign IRQ = irq_reg;
endmodule : sbsl_top
`default_nettype wire

// File: tb/sbsl_motor_model.sv
// motor speed source standing in for the machine side
// assumes the bench commands a non-negative target speed in rpm
`timescale 1ns/1ns
`default_nettype none
module sbsl_motor_model (
   input wire logic clk,
   input wire logic srst,
   input wire logic [15:0] cmd_speed,
   output logic [15:0] speed
);
   logic [15:0] speed_reg, speed_next;
   // a rotor cannot jump, so it slews 64 rpm a cycle
   always_comb begin
      speed_next = cmd_speed;
      if (cmd_speed > speed_reg + 16'h0040) speed_next = speed_reg + 16'h0040;
      else if (speed_reg > cmd_speed + 16'h0040) speed_next = speed_reg - 16'h0040;
   end
   always_ff @(posedge clk) begin
      speed_reg <= srst ? 16'h0000 : speed_next;
   end
   assign speed = speed_reg;
endmodule : sbsl_motor_model
`default_nettype wire

// File: tb/sbsl_sva.sv
// port checker for the servo status and brake block
// assumes address and data of a write are taken in one cycle
`timescale 1ns/1ns
`default_nettype none
module sbsl_sva
   import sbsl_pkg::*;
(
   input wire logic CLK,
   input wire logic SRST,
   input wire logic [31:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   input wire logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic S_AXI_WVALID,
   input wire logic S_AXI_WREADY,
   input wire logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic [15:0] MOTOR_SPEED,
   input wire logic [7:0] INPUT_TERMINALS,
   input wire logic [15:0] INPUT_FUNCTIONS,
   input wire logic [2:0] OUTPUT_TERMINALS,
   input wire logic MOTOR_EXCITE
);
   // ********
   // register mirror
   // ********
   logic [31:0] cfg_reg [16];
   logic brk2;
   default clocking @(posedge CLK); endclocking
   default disable iff (SRST);
   // snooped writes, one cycle ahead of the design's copy
   always_ff @(posedge CLK) begin
      if (SRST) begin
         for (int i = 0; i < 16; i++) begin
            cfg_reg[i] <= 32'h0000_0000;
         end
         cfg_reg[8] <= RST_IN_ASSIGN;
         cfg_reg[9] <= RST_OUT_ASSIGN;
      end else if (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY) begin
         if (S_AXI_AWADDR[7:6] == 2'b00) cfg_reg[S_AXI_AWADDR[5:2]] <= S_AXI_WDATA;
      end
   end
   assign brk2 = cfg_reg[9][11:8] == FUNC_BRAKE;
   // ********
   // assertions
   // ********
   a_bvalid_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
      else $error("write response dropped early");
   a_rvalid_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY
      |=> S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read data dropped early");
   a_reset_quiet: assert property (disable iff (1'b0)
      SRST |=> !MOTOR_EXCITE && OUTPUT_TERMINALS == 3'b000) else $error("outputs live in reset");
   a_rot_tracks: assert property (
      (cfg_reg[9][7:4] == 4'h1 && $stable(MOTOR_SPEED) && $stable(cfg_reg[1]))[*6]
      |-> OUTPUT_TERMINALS[1] == ($signed(MOTOR_SPEED) > $signed(cfg_reg[1][15:0])))
      else $error("rotation output wrong");
   a_brake_basic: assert property (brk2 && cfg_reg[6] == 0 && cfg_reg[7] == 0 &&
      $fell(MOTOR_EXCITE) |-> ##[0:1] !OUTPUT_TERMINALS[2]) else $error("brake late");
   a_son_pos: assert property (brk2 && $signed(cfg_reg[5]) > 0 &&
      $rose(OUTPUT_TERMINALS[2]) |-> !MOTOR_EXCITE) else $error("excited before delay");
   a_son_neg: assert property (brk2 && $signed(cfg_reg[5]) < 0 && $rose(MOTOR_EXCITE)
      |-> !OUTPUT_TERMINALS[2] ##1 !OUTPUT_TERMINALS[2]) else $error("brake freed early");
   a_func_map: assert property (
      (cfg_reg[8] == RST_IN_ASSIGN && $stable(INPUT_TERMINALS))[*6]
      |-> INPUT_FUNCTIONS[7:0] == INPUT_TERMINALS) else $error("input function map wrong");
endmodule : sbsl_sva
bind sbsl_top sbsl_sva i_sbsl_sva (.CLK, .SRST, .S_AXI_AWADDR, .S_AXI_AWVALID,
   .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BVALID,
   .S_AXI_BREADY, .S_AXI_RDATA, .S_AXI_RVALID, .S_AXI_RREADY, .MOTOR_SPEED,
   .INPUT_TERMINALS, .INPUT_FUNCTIONS, .OUTPUT_TERMINALS, .MOTOR_EXCITE);
`default_nettype wire

// File: tb/tb.sv
// self-checking bench for the servo status and brake block
// assumes the bench is the only axi master and the motor model sets speed
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, s) begin checked++; if ((e) !== (s)) begin fail_count++; \
   $display("[ERR] %s exp %h got %h", nm, e, s); end end
module tb
   import sbsl_pkg::*;
;
   logic clk = 0, srst = 1, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
   logic [31:0] awaddr = 0, wdata = 0, araddr = 0, pos_err = 0, seed = 32'h0000_3588, v, rdata;
   logic [15:0] cmd = 0, spd_ref = 0, speed;
   logic [7:0] terms = 0;
   logic [2:0] outs;
   logic excite, irq, awready, wready, bvalid, arready, rvalid;
   logic [63:0] q[$], e;
   logic [31:0] pe[4] = '{32'hFFFF_FFFC, 32'h0000_0005, 32'h0000_0100, 32'h0000_0101};
   logic [31:0] sw[4] = '{32'h0000_0001, 32'h0000_0000, 32'h0000_0001, 32'hFFFF_FFFF};
   logic [3:0] exv = 4'b1011, brv = 4'b0110;
   int fail_count = 0, checked = 0;
   sbsl_top i_sbsl_top (.CLK(clk), .SRST(srst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .MOTOR_SPEED(speed), .SPEED_REF(spd_ref), .POS_ERROR(pos_err),
      .INPUT_TERMINALS(terms), .INPUT_FUNCTIONS(), .OUTPUT_TERMINALS(outs),
      .MOTOR_EXCITE(excite), .IRQ(irq));
   sbsl_motor_model i_sbsl_motor_model (.clk(clk), .srst(srst), .cmd_speed(cmd), .speed(speed));
   // ********
   // helpers
   // ********
   initial forever #2 clk = ~clk;
   // xorshift keeps the run repeatable
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   // ready is raised late on purpose so the slave must hold its answer
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      awaddr <= 32'(a);
      wdata <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awv <= 1'b0;
         if (wready) wv <= 1'b0;
      end while (!bvalid);
      bready <= 1'b1;
      @(posedge clk);
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
      @(posedge clk);
      araddr <= 32'(a);
      arv <= 1'b1;
      q.push_back({m, x & m});
      do begin
         @(posedge clk);
         if (arready) arv <= 1'b0;
      end while (!rvalid);
      rready <= 1'b1;
      @(posedge clk);
      rready <= 1'b0;
   endtask : rd
   task automatic end_sim();
      $display("checks %0d errors %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_sim
   // oldest note against each returned read word
   always @(posedge clk) begin
      if (rvalid && rready) begin
         e = q.pop_front();
         `CHK("rdata", e[31:0], rdata & e[63:32])
      end
   end
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      end_sim();
   end
   // ********
   // scenarios
   // ********
   initial begin
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      terms <= 8'(rnd());
      rd(OFS_IN_ASSIGN, RST_IN_ASSIGN, 32'hFFFF_FFFF);
      rd(OFS_OUT_ASSIGN, RST_OUT_ASSIGN, 32'hFFFF_FFFF);
      rd(8'h40, RST_ZERO, 32'hFFFF_FFFF);
      wr(OFS_ROT_SPD, 32'h0000_01F4);
      wr(OFS_IRQ_MASK, 32'h0000_0001);
      for (int i = 0; i < 6; i++) begin
         v = (i < 2) ? 32'(500 + i) : rnd() % 1000;
         cmd <= v[15:0];
         repeat (30) @(posedge clk);
         rd(OFS_STATUS, 32'(v > 500), 32'h0000_0001);
      end
      cmd <= 16'h0064;
      wr(OFS_COIN_DIF, 32'h0000_000A);
      for (int k = 0; k < 4; k++) begin
         spd_ref <= k[1] ? 16'(91 - k[0]) : 16'(109 + k[0]);
         repeat (20) @(posedge clk);
         rd(OFS_STATUS, {30'h0000_0000, !k[0], 1'b0}, 32'h0000_0002);
      end
      wr(OFS_CTRL, 32'h0000_0002);
      wr(OFS_POS_THR, 32'h0000_0005);
      wr(OFS_OVF_THR, 32'h0000_0001);
      for (int i = 0; i < 4; i++) begin
         pos_err <= pe[i];
         repeat (8) @(posedge clk);
         rd(OFS_STATUS, {28'h000_0000, i == 3, i == 0, 2'b00}, 32'h0000_000C);
      end
      `CHK("irq", 1'b1, irq)
      pos_err <= 32'h0000_0000;
      wr(OFS_IRQ_STAT, 32'h0000_0001);
      repeat (4) @(posedge clk);
      `CHK("irq", 1'b0, irq)
      wr(OFS_CTRL, 32'h0000_0000);
      for (int i = 0; i < 4; i++) begin
         if (i == 1) wr(OFS_OUT_ASSIGN, 32'h0000_0410);
         wr(OFS_SON_WAIT, sw[i]);
         wr(OFS_CTRL, 32'h0000_0001);
         repeat (8) @(posedge clk);
         `CHK("excite", exv[i], excite)
         `CHK("brake", brv[i], outs[2])
         wr(OFS_CTRL, 32'h0000_0000);
         repeat (8) @(posedge clk);
         `CHK("off", 2'b00, {excite, outs[2]})
      end
      wr(OFS_SON_WAIT, 32'h0000_0000);
      wr(OFS_BRK_SPD, 32'h0000_0032);
      wr(OFS_BRK_TIME, 32'h0000_03E8);
      cmd <= 16'h00C8;
      wr(OFS_CTRL, 32'h0000_0001);
      repeat (8) @(posedge clk);
      wr(OFS_CTRL, 32'h0000_0000);
      repeat (8) @(posedge clk);
      `CHK("coast", 2'b01, {excite, outs[2]})
      cmd <= 16'h0000;
      repeat (30) @(posedge clk);
      `CHK("held", 1'b0, outs[2])
      wr(OFS_IN_ASSIGN, 32'h7654_3233);
      terms <= 8'h0E;
      repeat (8) @(posedge clk);
      rd(OFS_FUNC_VIEW, 32'h0000_0000, 32'h0000_0008);
      terms <= 8'h01;
      repeat (8) @(posedge clk);
      rd(OFS_FUNC_VIEW, 32'h0000_0008, 32'h0000_0008);
      end_sim();
   end
endmodule : tb
`default_nettype wire
